// file: pkg/sfp_pkg.sv
// package: constants and types of the stepper fault protection latch
package sfp_pkg;

    localparam int unsigned CLK_HZ             = 25000000;
    localparam int unsigned BLANK_TIME_NS      = 5500;
    localparam int unsigned ENABLE_WINDOW_NS   = 30000;
    localparam int unsigned CLEAR_SETUP_NS     = 10000;
    localparam int unsigned BLANK_CYC          = (BLANK_TIME_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned ENABLE_WINDOW_CYC  = (ENABLE_WINDOW_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned CLEAR_SETUP_CYC    = (CLEAR_SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CNT_W              = 11;

    localparam logic [1:0] KIND_NONE           = 2'h0;
    localparam logic [1:0] KIND_OPEN           = 2'h1;
    localparam logic [1:0] KIND_OVERCURRENT    = 2'h2;
    localparam logic [1:0] KIND_OVERHEAT       = 2'h3;

    typedef enum logic [2:0]
    {
        SFP_RUN     = 3'h1,
        SFP_TRIPPED = 3'h2,
        SFP_CLEAR   = 3'h4
    } sfp_state_e;

    typedef struct packed
    {
        logic open_seen;
        logic overcurrent;
        logic overheat;
    } sfp_detect_s;

endpackage : sfp_pkg

// file: design/sfp_fault_latch.sv
// design: fault detection, latching and reporting of a two-phase stepper driver
//
// Behaviour
// - any latched fault drives the open-drain any-fault output low.
// - fault-type code reports open, overcurrent or overheat as three levels.
// - every detector latches and forces all four phase outputs off.
// - only a system-clear low pulse or power-on reset clears the latch.
// - open terminal when no flyback current is seen in a PWM off time.
// - open detection trusted only above the minimum set current.
// - overcurrent flagged when phase current comparator reaches its threshold.
// - overcurrent comparator ignored for a blanking time after each PWM turn-on.
// - overheat flagged from the substrate temperature comparator.
// - negative-current PWM shortly after enable rises may trip open detection.
// - clear low holds reset; host waits after its release before stepping.
// - enable low forces phases off, excitation position is preserved.
`timescale 1ns/1ps
`default_nettype none

module sfp_fault_latch
    import sfp_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC
)
(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       system_clear_n,
    input  wire logic       enable,
    input  wire logic [3:0] phase_drive,
    input  wire logic       pwm_on,
    input  wire logic       flyback_seen,
    input  wire logic       current_above_min,
    input  wire logic       overcurrent_cmp,
    input  wire logic       overheat_cmp,
    output logic [3:0]      phase_out,
    output logic            any_fault_n_o,
    output logic            any_fault_n_oe,
    output logic [1:0]      fault_kind_level,
    output logic            step_ready,
    output logic            enable_window
);

    // ****************************************************
    // reset synchroniser
    // ****************************************************
    logic rst_s1_q;
    logic rst_s2_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire logic rst_n = rst_s2_q;

    // ****************************************************
    // helpers
    // ****************************************************
    // priority encode of simultaneous hits: overheat, overcurrent, open
    function automatic logic [1:0] kind_of
    (
        input sfp_detect_s hit
    );
        logic [1:0] code;
        code = KIND_NONE;
        if (hit.overheat)
            code = KIND_OVERHEAT;
        else if (hit.overcurrent)
            code = KIND_OVERCURRENT;
        else if (hit.open_seen)
            code = KIND_OPEN;
        return code;
    endfunction

    // saturating one-step count down
    function automatic logic [CNT_W-1:0] count_down
    (
        input logic [CNT_W-1:0] value
    );
        logic [CNT_W-1:0] next;
        next = value;
        if (value != '0)
            next = value - 1'b1;
        return next;
    endfunction

    // ****************************************************
    // detection
    // ****************************************************
    logic              pwm_on_q;
    logic              off_flyback_q;
    logic [CNT_W-1:0]  blank_cnt_q;
    logic [CNT_W-1:0]  blank_cnt_d;
    logic [CNT_W-1:0]  win_cnt_q;
    logic [CNT_W-1:0]  win_cnt_d;
    logic              enable_q;
    logic              off_flyback_d;
    sfp_detect_s       det;

    always_comb
    begin
        blank_cnt_d   = blank_cnt_q;
        off_flyback_d = off_flyback_q;
        win_cnt_d     = win_cnt_q;
        // turn-on edge restarts blanking
        if (pwm_on && !pwm_on_q)
            blank_cnt_d = CNT_W'(BLANK_CYCLES);
        else
            blank_cnt_d = count_down(blank_cnt_q);
        // flyback observed in the off time after its first cycle, which clears the flag
        if (!pwm_on && pwm_on_q)
            off_flyback_d = 1'b0;
        else if (!pwm_on && flyback_seen)
            off_flyback_d = 1'b1;
        // enable rising opens the sensitive window
        if (enable && !enable_q)
            win_cnt_d = CNT_W'(ENABLE_WINDOW_CYC);
        else
            win_cnt_d = count_down(win_cnt_q);
        det.open_seen   = pwm_on && !pwm_on_q && enable_q && !off_flyback_q
                          && current_above_min;
        // the turn-on cycle itself is blanked, the counter only loads at its end
        det.overcurrent = overcurrent_cmp && pwm_on && pwm_on_q && (blank_cnt_q == '0);
        det.overheat    = overheat_cmp;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwm_on_q      <= 1'b0;
            off_flyback_q <= 1'b1;
            blank_cnt_q   <= '0;
            win_cnt_q     <= '0;
            enable_q      <= 1'b0;
        end
        else
        begin
            pwm_on_q      <= pwm_on;
            off_flyback_q <= off_flyback_d;
            blank_cnt_q   <= blank_cnt_d;
            win_cnt_q     <= win_cnt_d;
            enable_q      <= enable;
        end
    end

    // ****************************************************
    // fault latch
    // ****************************************************
    sfp_state_e        state_q;
    sfp_state_e        state_d;
    logic [1:0]        kind_q;
    logic [1:0]        kind_d;
    logic [CNT_W-1:0]  clr_cnt_q;
    logic [CNT_W-1:0]  clr_cnt_d;

    always_comb
    begin
        state_d   = state_q;
        kind_d    = kind_q;
        clr_cnt_d = clr_cnt_q;
        case (state_q)
            SFP_RUN:
            begin
                if (!system_clear_n)
                begin
                    state_d = SFP_CLEAR;
                end
                else if (kind_of(det) != KIND_NONE)
                begin
                    state_d = SFP_TRIPPED;
                    kind_d  = kind_of(det);
                end
                clr_cnt_d = count_down(clr_cnt_q);
            end
            SFP_TRIPPED:
            begin
                // type frozen until clear
                if (!system_clear_n)
                begin
                    // pin and type drop together
                    state_d = SFP_CLEAR;
                    kind_d  = KIND_NONE;
                end
            end
            SFP_CLEAR:
            begin
                kind_d = KIND_NONE;
                if (system_clear_n)
                begin
                    state_d   = SFP_RUN;
                    clr_cnt_d = CNT_W'(CLEAR_SETUP_CYC);
                end
            end
            default:
            begin
                state_d = SFP_RUN;
                kind_d  = KIND_NONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= SFP_RUN;
            kind_q    <= KIND_NONE;
            clr_cnt_q <= '0;
        end
        else
        begin
            state_q   <= state_d;
            kind_q    <= kind_d;
            clr_cnt_q <= clr_cnt_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic       flt_oe_q;
    logic       ready_q;

    // phases follow the next state so they drop with the fault pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_phase
            assign phase_d[gi] = phase_drive[gi] && (state_d == SFP_RUN) && enable;
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q  <= '0;
            flt_oe_q <= 1'b0;
            ready_q  <= 1'b0;
        end
        else
        begin
            phase_q  <= phase_d;
            flt_oe_q <= (state_d == SFP_TRIPPED);
            ready_q  <= (state_d == SFP_RUN) && (clr_cnt_d == '0);
        end
    end

    assign phase_out        = phase_q;
    assign any_fault_n_o    = 1'b0;
    assign any_fault_n_oe   = flt_oe_q;
    assign fault_kind_level = kind_q;
    assign step_ready       = ready_q;
    assign enable_window    = (win_cnt_q != '0);

endmodule // sfp_fault_latch

`default_nettype wire

// file: verification/sfp_fault_latch_checker.sv
// checker: port assertions of the fault latch
`timescale 1ns/1ps
`default_nettype none
// ****************
// port assertions
// ****************
module sfp_fault_latch_checker
    import sfp_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC
)
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       system_clear_n,
    input wire logic       enable,
    input wire logic [3:0] phase_drive,
    input wire logic       pwm_on,
    input wire logic       flyback_seen,
    input wire logic       current_above_min,
    input wire logic       overcurrent_cmp,
    input wire logic       overheat_cmp,
    input wire logic [3:0] phase_out,
    input wire logic       any_fault_n_o,
    input wire logic       any_fault_n_oe,
    input wire logic [1:0] fault_kind_level,
    input wire logic       step_ready,
    input wire logic       enable_window
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_run;
        system_clear_n[*3] ##0 !any_fault_n_oe;
    endsequence
    sequence s_blank;
        $rose(pwm_on) && !any_fault_n_oe ##1 (!overheat_cmp && system_clear_n)[*3];
    endsequence
    fault_off_a: assert property (any_fault_n_oe |-> phase_out == 4'h0) else $error("phase on in fault");
    fault_pin_a: assert property (!any_fault_n_o && any_fault_n_oe == (fault_kind_level != KIND_NONE))
        else $error("fault pin and kind differ");
    heat_trip_a: assert property (s_run ##0 overheat_cmp |=> any_fault_n_oe && fault_kind_level == KIND_OVERHEAT)
        else $error("overheat not latched");
    oc_trip_a: assert property ((pwm_on && system_clear_n)[*8] ##0 (overcurrent_cmp && !overheat_cmp &&
        !any_fault_n_oe) |=> fault_kind_level == KIND_OVERCURRENT) else $error("overcurrent not latched");
    oc_blank_a: assert property (s_blank |=> fault_kind_level != KIND_OVERCURRENT) else $error("blanking lost");
    kind_hold_a: assert property (any_fault_n_oe && system_clear_n |=> any_fault_n_oe && $stable(fault_kind_level))
        else $error("latch changed");
    clear_drop_a: assert property (!system_clear_n |=> !any_fault_n_oe && fault_kind_level == KIND_NONE)
        else $error("clear ignored");
    enable_off_a: assert property (!enable[*2] |=> phase_out == 4'h0) else $error("phase on while disabled");
endmodule // sfp_fault_latch_checker
`default_nettype wire

// file: verification/sfp_motor_model.sv
// model: chopper timing and winding flyback seen by the fault latch
`timescale 1ns/1ps
`default_nettype none
// ****************
// chopper and winding
// ****************
module sfp_motor_model
(
    input  wire logic clk_sys,
    input  wire logic chop,
    input  wire logic winding_open,
    output logic      pwm_on,
    output logic      flyback_seen
);
    logic [4:0] cnt_q;
    always_ff @(posedge clk_sys)
    begin
        cnt_q <= (!chop || cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
    end
    // host holds chopping off until chop is raised
    assign pwm_on       = chop && (cnt_q < 5'h0C);
    // flyback flows in the off time through a closed winding only
    assign flyback_seen = !pwm_on && !winding_open;
endmodule // sfp_motor_model
`default_nettype wire

// file: verification/sfp_fault_latch_tb_top.sv
// testbench: fault latch scenarios
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module sfp_fault_latch_tb_top;
    import sfp_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, system_clear_n = 1'b1, enable = 1'b1, chop = 1'b0;
    logic current_above_min = 1'b1, overcurrent_cmp = 1'b0, overheat_cmp = 1'b0, winding_open = 1'b0;
    logic [3:0] phase_drive = 4'h5, phase_out;
    logic [1:0] fault_kind_level;
    logic       pwm_on, flyback_seen, any_fault_n_o, any_fault_n_oe, step_ready, enable_window;
    int         n_mismatch = 0, total_checks = 0, cycles = 0;
    sfp_fault_latch #(.BLANK_CYCLES(4)) sfp_fault_latch_i (.clk_sys, .arst_n, .system_clear_n, .enable,
        .phase_drive, .pwm_on, .flyback_seen, .current_above_min, .overcurrent_cmp, .overheat_cmp,
        .phase_out, .any_fault_n_o, .any_fault_n_oe, .fault_kind_level, .step_ready, .enable_window);
    sfp_motor_model sfp_motor_model_i (.clk_sys, .chop, .winding_open, .pwm_on, .flyback_seen);
    always #20 clk_sys = ~clk_sys;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic clear_latch;
        system_clear_n = 1'b0;
        cyc(2);
        chk({1'b0, any_fault_n_oe, fault_kind_level}, 4'h0);
        system_clear_n = 1'b1;
        cyc(2);
        chk({3'h0, step_ready}, 4'h0);
        cyc(260);
        chk({3'h0, step_ready}, 4'h1);
    endtask
    task automatic heat_then_oc;
        overheat_cmp = 1'b1;
        cyc(1);
        overheat_cmp = 1'b0;
        overcurrent_cmp = 1'b1;
        cyc(1);
        chk({any_fault_n_o, any_fault_n_oe, fault_kind_level}, {2'b01, KIND_OVERHEAT});
        chk(phase_out, 4'h0);
        cyc(30);
        chk({2'h0, fault_kind_level}, {2'h0, KIND_OVERHEAT});
        overcurrent_cmp = 1'b0;
        clear_latch();
    endtask
    task automatic oc_blank_then_trip;
        while (pwm_on !== 1'b0) cyc(1);
        while (pwm_on !== 1'b1) cyc(1);
        overcurrent_cmp = 1'b1;
        cyc(2);
        overcurrent_cmp = 1'b0;
        cyc(3);
        chk({3'h0, any_fault_n_oe}, 4'h0);
        overcurrent_cmp = 1'b1;
        cyc(20);
        chk({2'h0, fault_kind_level}, {2'h0, KIND_OVERCURRENT});
        overcurrent_cmp = 1'b0;
        clear_latch();
    endtask
    task automatic open_winding;
        winding_open = 1'b1;
        current_above_min = 1'b0;
        cyc(45);
        chk({3'h0, any_fault_n_oe}, 4'h0);
        current_above_min = 1'b1;
        cyc(45);
        chk({2'h0, fault_kind_level}, {2'h0, KIND_OPEN});
        winding_open = 1'b0;
        clear_latch();
    endtask
    task automatic enable_pause;
        enable = 1'b0;
        cyc(3);
        chk(phase_out, 4'h0);
        enable = 1'b1;
        cyc(3);
        chk(phase_out, 4'h5);
        chk({3'h0, enable_window}, 4'h1);
    endtask
    initial
    begin
        cyc(2);
        arst_n = 1'b1;
        cyc(4);
        chop = 1'b1;
        cyc(2);
        enable_pause();
        heat_then_oc();
        oc_blank_then_trip();
        open_winding();
        stop_test();
    end
endmodule // sfp_fault_latch_tb_top
bind sfp_fault_latch sfp_fault_latch_checker #(.BLANK_CYCLES(BLANK_CYCLES)) sfp_fault_latch_checker_i (.clk_sys,
    .arst_n, .system_clear_n, .enable, .phase_drive, .pwm_on, .flyback_seen, .current_above_min, .overcurrent_cmp,
    .overheat_cmp, .phase_out, .any_fault_n_o, .any_fault_n_oe, .fault_kind_level, .step_ready, .enable_window);
`default_nettype wire
